/* File: rtl/ecl_pkg.sv */
// Constants, types and preset table of the memory interface configuration loader.
//
// Function
// - After reset, sense input is read twice: internal preset check, then external scan.
// - Internal scan covers 66 input clocks inside a 144 input clock window.
// - Write, refresh and address lines start high, then fall in turn two clocks apart.
// - Sense input following a scanned line selects that line's preset configuration.
// - Default: T-states 4, strobes 31/30/30/18, late write, refresh 72, 12 cycles.
// - Only 16 lines give presets; any other match keeps the default configuration.
// - Presets on lines 8 and 9 (address lines 6 and 7) have refresh disabled, static memory only.
// - Sense held low until the write line falls selects the external configuration.
// - External scan always runs; its bits are dropped when a preset was chosen.
// - External scan is 36 read cycles in default timing, one sense bit each.
// - Scan read addresses run from 7FFFFF6C in steps of four to 7FFFFFF8.
// - Sense tied low gives maximum T-states and strobes, refresh 72 on, late write.
// - First 12 bits are six 2-bit fields, LSB first: extra half-periods per T-state.
// - Bits 13 to 32 are four 5-bit strobe fields, LSB first, 0 to 31.
// - Bits 33-34 refresh code, bit 35 refresh enable, bit 36 late write.
// - Refresh code 00,01,10,11 maps to 18,36,54,72 input clocks.
// - An extra half-period after T6 makes the next T1 start on a rising edge.
// - With wait states, T5 on a falling edge gets one more half-period.
package ecl_pkg;

   localparam int ECL_CLK_MHZ        = 50;
   localparam int ECL_CLKIN_NS       = 200;
   localparam int ECL_CLKIN_DIV      = ECL_CLKIN_NS * ECL_CLK_MHZ / 1000;
   localparam int ECL_HALF_NS        = 40;
   localparam int ECL_HALF_DIV       = ECL_HALF_NS * ECL_CLK_MHZ / 1000;

   localparam logic [7:0]  ECL_SCAN_START  = 8'h10;
   localparam logic [7:0]  ECL_SCAN_SPAN   = 8'h42;
   localparam logic [7:0]  ECL_WIN_LAST    = 8'h8f;
   localparam int          ECL_LINES       = 33;
   localparam logic [5:0]  ECL_EXT_LAST    = 6'h23;
   localparam logic [31:0] ECL_EXT_BASE    = 32'h7fffff6c;
   localparam logic [5:0]  ECL_PRESET_MAX  = 6'h0f;
   localparam logic [4:0]  ECL_DEFAULT_IDX = 5'h10;
   localparam logic [1:0]  ECL_REF_72      = 2'h3;
   localparam logic [6:0]  ECL_REF_UNIT    = 7'h12;

   typedef struct packed {
      logic [5:0][2:0] t_len;
      logic [3:0][4:0] strobe;
      logic            late_write;
      logic            refresh_en;
      logic [1:0]      refresh_code;
      logic [3:0]      proc_cycles;
   } ecl_cfg_t;

   typedef enum logic [2:0] {
      ST_INT  = 3'b001,
      ST_EXT  = 3'b010,
      ST_DONE = 3'b100
   } ecl_state_t;

   function automatic ecl_cfg_t ecl_mk(input int t1, t2, t3, t4, t5, t6,
                                       input int s1, s2, s3, s4,
                                       input int lw, re, pc);
      ecl_cfg_t c;
      c.t_len        = {3'(t6), 3'(t5), 3'(t4), 3'(t3), 3'(t2), 3'(t1)};
      c.strobe       = {5'(s4), 5'(s3), 5'(s2), 5'(s1)};
      c.late_write   = 1'(lw);
      c.refresh_en   = 1'(re);
      c.refresh_code = ECL_REF_72;
      c.proc_cycles  = 4'(pc);
      return c;
   endfunction

   function automatic logic [6:0] ecl_ref_clks(input logic [1:0] code);
      return 7'(ECL_REF_UNIT * ({5'h00, code} + 7'h01));
   endfunction

   // Index 0 is the write line, 1 the refresh line, 2..15 address lines, 16 the default.
   localparam ecl_cfg_t ECL_PRESETS [17] = '{
      ecl_mk(1, 1, 1, 1, 1, 1, 30, 1, 3,  5, 1, 1,  3),
      ecl_mk(1, 2, 1, 1, 1, 2, 30, 1, 2,  7, 1, 1,  4),
      ecl_mk(1, 2, 1, 1, 2, 3, 30, 1, 2,  7, 1, 1,  5),
      ecl_mk(2, 3, 1, 1, 2, 3, 30, 1, 3,  8, 1, 1,  6),
      ecl_mk(1, 1, 1, 1, 1, 1,  3, 1, 2,  3, 0, 1,  3),
      ecl_mk(1, 1, 2, 1, 2, 1,  5, 1, 2,  3, 0, 1,  4),
      ecl_mk(2, 1, 2, 1, 3, 1,  6, 1, 2,  3, 0, 1,  5),
      ecl_mk(2, 2, 2, 1, 3, 2,  7, 1, 3,  4, 0, 1,  6),
      ecl_mk(1, 1, 1, 1, 1, 1, 30, 1, 2,  3, 0, 0,  3),
      ecl_mk(1, 1, 2, 1, 2, 1, 30, 2, 5,  9, 0, 0,  4),
      ecl_mk(2, 2, 2, 2, 4, 2, 30, 2, 3,  8, 1, 1,  7),
      ecl_mk(3, 3, 3, 3, 3, 3, 30, 2, 4, 13, 1, 1,  9),
      ecl_mk(1, 1, 2, 1, 2, 1,  4, 1, 2,  3, 0, 1,  4),
      ecl_mk(2, 1, 2, 1, 2, 2,  5, 1, 2,  3, 0, 1,  5),
      ecl_mk(2, 2, 2, 1, 3, 2,  6, 1, 3,  4, 0, 1,  6),
      ecl_mk(2, 1, 2, 3, 3, 3,  8, 1, 2,  3, 0, 1,  7),
      ecl_mk(4, 4, 4, 4, 4, 4, 31, 30, 30, 18, 1, 1, 12)
   };

   localparam ecl_cfg_t ECL_DEFAULT_CFG = ECL_PRESETS[16];

endpackage

/* File: rtl/ecl_tick_div.sv */
// Divider that turns the system clock into a one-cycle enable pulse.
`timescale 1ns/100ps
module ecl_tick_div #(
   parameter int DIV = 10
) (
   // Clock and reset
   input  logic mclk,
   input  logic reset,
   // Enable pulse
   output logic tick
);
   logic [7:0] cnt_reg;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cnt_reg <= 8'h00;
         tick    <= 1'b0;
      end
      else if (cnt_reg == 8'(DIV - 1))
      begin
         cnt_reg <= 8'h00;
         tick    <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 8'h01;
         tick    <= 1'b0;
      end
   end
endmodule // ecl_tick_div

/* File: rtl/ecl_preset_rom.sv */
// Constant preset table with a registered read port.
`timescale 1ns/100ps
module ecl_preset_rom (
   // Clock and reset
   input  logic             mclk,
   input  logic             reset,
   // Read port
   input  logic [4:0]       idx,
   output ecl_pkg::ecl_cfg_t rdata
);
   import ecl_pkg::*;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         rdata <= ECL_DEFAULT_CFG;
      else if (idx > ECL_DEFAULT_IDX)
         rdata <= ECL_DEFAULT_CFG;
      else
         rdata <= ECL_PRESETS[idx];
   end
endmodule // ecl_preset_rom

/* File: rtl/ecl_config_loader.sv */
// Post-reset loader that picks the memory interface timing from presets or a ROM scan.
`timescale 1ns/100ps
module ecl_config_loader (
   // Clock and reset
   input  logic              mclk,
   input  logic              reset,
   // Configuration pins
   input  logic              cfg_sense_input,
   input  logic              mem_wait,
   // Bus lines
   output logic              write_data0_line,
   output logic              refresh_data1_line,
   output logic [30:0]       muxed_addr_data_lines,
   output logic              cycle_strobe_0_n,
   output logic              read_strobe_n,
   output logic              proc_clock_out_a,
   // Result
   output ecl_pkg::ecl_cfg_t cfg_out,
   output logic              cfg_valid,
   output logic              ext_cfg_used,
   output logic [6:0]        refresh_interval_clks
);
   import ecl_pkg::*;

   ecl_state_t      state_reg;
   logic            clkin_tick;
   logic            hp_tick;
   logic [7:0]      win_cnt_reg;
   logic [7:0]      scan_off;
   logic            ext_sel_reg;
   logic            found_reg;
   logic [5:0]      match_reg;
   logic [4:0]      rom_idx;
   ecl_cfg_t        rom_data;
   logic [32:0]     line_int;
   logic [2:0]      tphase_reg;
   logic [2:0]      hp_cnt_reg;
   logic            align_reg;
   logic            waited_reg;
   logic [5:0]      ext_idx_reg;
   logic [35:0]     ext_bits_reg;
   logic [2:0]      cur_len;
   logic            t_end;
   logic            hold_wait;
   logic            ext_end;
   logic            busy_t;
   logic [31:0]     ext_addr;
   ecl_cfg_t        ext_cfg;
   logic [4:0]      ext_sum;
   logic [32:0]     bus_reg;

   ecl_tick_div #(.DIV(ECL_CLKIN_DIV)) u_clkin_div (
      .mclk  (mclk),
      .reset (reset),
      .tick  (clkin_tick)
   );

   ecl_tick_div #(.DIV(ECL_HALF_DIV)) u_hp_div (
      .mclk  (mclk),
      .reset (reset),
      .tick  (hp_tick)
   );

   // Unmatched lines and lines beyond the table fall back to the default entry.
   assign rom_idx = (found_reg && match_reg <= ECL_PRESET_MAX) ? match_reg[4:0]
                                                               : ECL_DEFAULT_IDX;

   ecl_preset_rom u_rom (
      .mclk  (mclk),
      .reset (reset),
      .idx   (rom_idx),
      .rdata (rom_data)
   );

   // Top sequence: internal window, then the external scan, then hold.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         state_reg <= ST_INT;
      else
      begin
         case (state_reg)
            ST_INT:
               if (clkin_tick && win_cnt_reg == ECL_WIN_LAST)
                  state_reg <= ST_EXT;
            ST_EXT:
               if (ext_end)
                  state_reg <= ST_DONE;
            ST_DONE:
               state_reg <= ST_DONE;
            default:
               state_reg <= ST_INT;
         endcase
      end
   end

   // Internal scan window counter and sense sampling.
   assign scan_off = win_cnt_reg - ECL_SCAN_START;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         win_cnt_reg <= 8'h00;
      else if (state_reg == ST_INT && clkin_tick)
         win_cnt_reg <= win_cnt_reg + 8'h01;
   end

   // The sense input is sampled at slot end, two input clocks after each line falls.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ext_sel_reg <= 1'b0;
         found_reg   <= 1'b0;
         match_reg   <= 6'h00;
      end
      else if (state_reg == ST_INT && clkin_tick)
      begin
         if (win_cnt_reg == ECL_SCAN_START - 8'h01)
            ext_sel_reg <= !cfg_sense_input;
         else if (win_cnt_reg >= ECL_SCAN_START && scan_off[0] &&
                  scan_off < ECL_SCAN_SPAN && !found_reg && !cfg_sense_input)
         begin
            found_reg <= 1'b1;
            match_reg <= scan_off[6:1];
         end
      end
   end

   // Each line stays high until its slot, then low until the window ends.
   generate
      for (genvar k = 0; k < ECL_LINES; k++)
      begin : g_line
         assign line_int[k] = (win_cnt_reg < 8'(ECL_SCAN_START + 8'(2 * k)));
      end
   endgenerate

   // External read cycle engine, stepped on every half processor period.
   assign cur_len   = ECL_DEFAULT_CFG.t_len[tphase_reg];
   assign t_end     = (hp_cnt_reg == cur_len - 3'h1);
   assign hold_wait = (tphase_reg == 3'h3) && t_end && mem_wait;
   // The T5 alignment period belongs to the read, so the strobes stay asserted through it.
   assign busy_t    = (state_reg == ST_EXT) && !(align_reg && tphase_reg == 3'h5);
   assign ext_end   = (state_reg == ST_EXT) && hp_tick && !align_reg &&
                      tphase_reg == 3'h5 && t_end && ext_idx_reg == ECL_EXT_LAST;
   assign ext_addr  = ECL_EXT_BASE + {24'h000000, ext_idx_reg, 2'h0};

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         proc_clock_out_a <= 1'b0;
      else if (hp_tick)
         proc_clock_out_a <= !proc_clock_out_a;
   end

   // A tick while the clock output is low is the boundary of a rising edge.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tphase_reg  <= 3'h5;
         hp_cnt_reg  <= 3'h0;
         align_reg   <= 1'b1;
         waited_reg  <= 1'b0;
         ext_idx_reg <= 6'h00;
      end
      else if (state_reg == ST_EXT && hp_tick)
      begin
         if (align_reg)
         begin
            if (tphase_reg != 3'h5)
            begin
               align_reg  <= 1'b0;
               tphase_reg <= 3'h4;
               hp_cnt_reg <= 3'h0;
            end
            else if (!proc_clock_out_a)
            begin
               align_reg  <= 1'b0;
               tphase_reg <= 3'h0;
               hp_cnt_reg <= 3'h0;
               waited_reg <= 1'b0;
            end
         end
         else if (hold_wait)
            waited_reg <= 1'b1;
         else if (t_end)
         begin
            hp_cnt_reg <= 3'h0;
            if (tphase_reg == 3'h3 && waited_reg && proc_clock_out_a)
               align_reg <= 1'b1;
            else if (tphase_reg == 3'h5)
            begin
               if (ext_idx_reg != ECL_EXT_LAST)
               begin
                  ext_idx_reg <= ext_idx_reg + 6'h01;
                  waited_reg  <= 1'b0;
                  if (proc_clock_out_a)
                     align_reg <= 1'b1;
                  else
                     tphase_reg <= 3'h0;
               end
            end
            else
               tphase_reg <= tphase_reg + 3'h1;
         end
         else
            hp_cnt_reg <= hp_cnt_reg + 3'h1;
      end
   end

   // One bit per cycle, taken at the end of T5; the pin carries the inverted value.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ext_bits_reg <= 36'h0;
      else if (busy_t && hp_tick && !hold_wait && tphase_reg == 3'h4 && t_end)
         ext_bits_reg[ext_idx_reg] <= !cfg_sense_input;
   end

   // Field decode of the scanned bit stream.
   generate
      for (genvar i = 0; i < 6; i++)
      begin : g_tfield
         assign ext_cfg.t_len[i] = {1'b0, ext_bits_reg[2*i+1 -: 2]} + 3'h1;
      end
      for (genvar j = 0; j < 4; j++)
      begin : g_sfield
         assign ext_cfg.strobe[j] = ext_bits_reg[12+5*j +: 5];
      end
   endgenerate

   assign ext_cfg.refresh_code = ext_bits_reg[33:32];
   assign ext_cfg.refresh_en   = ext_bits_reg[34];
   assign ext_cfg.late_write   = ext_bits_reg[35];
   // The cycle is rounded up to whole processor cycles, matching the T6 extension.
   assign ext_sum = 5'(ext_cfg.t_len[0]) + 5'(ext_cfg.t_len[1]) + 5'(ext_cfg.t_len[2]) +
                    5'(ext_cfg.t_len[3]) + 5'(ext_cfg.t_len[4]) + 5'(ext_cfg.t_len[5]);
   assign ext_cfg.proc_cycles = 4'((ext_sum + 5'h01) >> 1);

   // Result latch; nothing after the scan can change it short of a reset.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cfg_out               <= ECL_DEFAULT_CFG;
         cfg_valid             <= 1'b0;
         ext_cfg_used          <= 1'b0;
         refresh_interval_clks <= 7'h00;
      end
      else if (ext_end)
      begin
         cfg_valid <= 1'b1;
         ext_cfg_used <= ext_sel_reg;
         if (ext_sel_reg)
         begin
            cfg_out               <= ext_cfg;
            refresh_interval_clks <= ecl_ref_clks(ext_cfg.refresh_code);
         end
         else
         begin
            cfg_out               <= rom_data;
            refresh_interval_clks <= ecl_ref_clks(rom_data.refresh_code);
         end
      end
   end

   // Bus line drive: scan pattern, then address in T1 and T2 of each read.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         bus_reg          <= '1;
         cycle_strobe_0_n <= 1'b1;
         read_strobe_n    <= 1'b1;
      end
      else
      begin
         if (state_reg == ST_INT)
            bus_reg <= line_int;
         else if (busy_t && tphase_reg <= 3'h1)
            bus_reg <= {1'b0, ext_addr[31:2], 2'h3};
         else
            bus_reg <= '1;
         cycle_strobe_0_n <= !(busy_t && tphase_reg != 3'h0);
         read_strobe_n    <= !(busy_t && tphase_reg >= 3'h2 && tphase_reg <= 3'h4);
      end
   end

   assign write_data0_line      = bus_reg[0];
   assign refresh_data1_line    = bus_reg[1];
   assign muxed_addr_data_lines = bus_reg[32:2];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   AST_HOLD_CFG: assert property (cfg_valid |=> cfg_valid && $stable(cfg_out))
      else $error("configuration changed after latch");
   AST_LINE_ORDER: assert property (state_reg == ST_INT |->
         ((~line_int) & ((~line_int) + 33'h1)) == 33'h0)
      else $error("scan lines not falling in order");
   AST_WINDOW_END: assert property (state_reg == ST_INT && clkin_tick &&
         win_cnt_reg == ECL_WIN_LAST |=> state_reg == ST_EXT)
      else $error("internal window not 144 clocks");
   AST_EXT_IDX: assert property (state_reg == ST_EXT |-> ext_idx_reg <= ECL_EXT_LAST)
      else $error("scan read count overrun");
   AST_ADDR_OUT: assert property (busy_t && tphase_reg == 3'h0 |=>
         {muxed_addr_data_lines[29:0], 2'h0} ==
         32'h7fffff6c + {24'h000000, $past(ext_idx_reg), 2'h0})
      else $error("scan address wrong");
   AST_T5_ALIGN: assert property (busy_t && hp_tick && tphase_reg == 3'h3 && t_end &&
         !mem_wait && waited_reg && proc_clock_out_a |=> align_reg)
      else $error("missing T5 alignment period");
   AST_T1_RISE: assert property (tphase_reg == 3'h0 && $past(tphase_reg) == 3'h5 |->
         !$past(proc_clock_out_a))
      else $error("T1 started on falling edge");
   AST_PRESET_PICK: assert property ($rose(cfg_valid) && !ext_cfg_used |->
         cfg_out == $past(rom_data))
      else $error("preset not applied");
   AST_STATIC_ONLY: assert property ($rose(cfg_valid) && !ext_cfg_used && found_reg &&
         (match_reg == 6'h08 || match_reg == 6'h09) |-> !cfg_out.refresh_en)
      else $error("static preset has refresh");
   AST_REF_MAP: assert property (cfg_valid |->
         refresh_interval_clks == 7'(18 * (int'(cfg_out.refresh_code) + 1)))
      else $error("refresh interval mapping wrong");
   AST_GND_CFG: assert property ($rose(cfg_valid) && ext_cfg_used &&
         (&ext_bits_reg) |-> cfg_out.t_len == {6{3'h4}} && cfg_out.strobe == {4{5'h1f}} &&
         cfg_out.late_write && cfg_out.refresh_en)
      else $error("grounded sense result wrong");
   AST_DEFAULT: assert property ($rose(cfg_valid) && !ext_cfg_used &&
         !found_reg |-> cfg_out == ECL_DEFAULT_CFG)
      else $error("default configuration wrong");

   COV_EXT: cover property ($rose(cfg_valid) && ext_cfg_used);
   COV_PRESET: cover property ($rose(cfg_valid) && !ext_cfg_used && found_reg);
   COV_WAIT_ALIGN: cover property (align_reg && tphase_reg == 3'h3);
endmodule // ecl_config_loader

/* File: bench/ecl_cfg_partner.sv */
// Strap wiring and configuration ROM model that drives the sense input and wait.
`timescale 1ns/100ps
module ecl_cfg_partner (
   // Clock and reset
   input  logic        mclk,
   input  logic        reset,
   // Scenario selection
   input  logic [1:0]  mode,
   input  logic [5:0]  line_sel,
   input  logic [35:0] rom_bits,
   input  logic        slow,
   // Bus lines from the device
   input  logic        write_data0_line,
   input  logic        refresh_data1_line,
   input  logic [30:0] muxed_addr_data_lines,
   input  logic        cycle_strobe_0_n,
   input  logic        read_strobe_n,
   // Answers to the device, plus read count and address error for the bench
   output logic        cfg_sense_input,
   output logic        mem_wait,
   output int          rd_count,
   output logic        addr_err
);
   logic [32:0] lines;
   logic [31:0] addr;
   logic [5:0]  idx;
   logic        s0_prev;
   logic        rs_prev;
   int          wait_cnt;

   assign lines = {muxed_addr_data_lines, refresh_data1_line, write_data0_line};
   assign addr  = {muxed_addr_data_lines[29:0], 2'h0};

   // Outside a read the inverter sees the device's own data line 0, as on a real board.
   always_comb
      case (mode)
         2'h0:    cfg_sense_input = 1'b1;
         2'h1:    cfg_sense_input = 1'b0;
         2'h2:    cfg_sense_input = lines[line_sel];
         default: cfg_sense_input = read_strobe_n ? ~write_data0_line
                                                  : ~rom_bits[idx];
      endcase

   always @(posedge mclk or posedge reset)
      if (reset)
      begin
         s0_prev  <= 1'b1;
         rd_count <= 0;
         addr_err <= 1'b0;
         idx      <= 6'h00;
      end
      else
      begin
         s0_prev <= cycle_strobe_0_n;
         if (s0_prev && !cycle_strobe_0_n)
         begin
            if (rd_count > 35 || addr !== 32'h7fffff6c + 32'(4 * rd_count)
                || muxed_addr_data_lines[30] !== 1'b0)
               addr_err <= 1'b1;
            if (rd_count < 36)
               idx <= 6'(rd_count);
            rd_count <= rd_count + 1;
         end
      end

   // A slow ROM holds wait for 18 clocks per read, which gives an odd number of wait periods.
   // That forces the T5 alignment period and stays well inside the permitted extension.
   always @(posedge mclk or posedge reset)
      if (reset)
      begin
         rs_prev  <= 1'b1;
         wait_cnt <= 0;
         mem_wait <= 1'b0;
      end
      else
      begin
         rs_prev <= read_strobe_n;
         if (slow && rs_prev && !read_strobe_n)
            wait_cnt <= 18;
         else if (wait_cnt != 0)
            wait_cnt <= wait_cnt - 1;
         mem_wait <= (slow && rs_prev && !read_strobe_n) || wait_cnt > 1;
      end
endmodule // ecl_cfg_partner

/* File: bench/ecl_config_loader_tb.sv */
// Self-checking bench for the configuration loader against an integer model.
`timescale 1ns/100ps
module ecl_config_loader_tb;
   import ecl_pkg::*;
   logic        mclk, reset, sense, mem_wait, wr0, rf1, s0_n, rd_n, pclk, valid, ext_used, err;
   logic        slow;
   logic [30:0] ad;
   logic [6:0]  ref_clks;
   logic [1:0]  mode;
   logic [5:0]  line_sel;
   logic [35:0] bits;
   ecl_cfg_t    cfg, dflt;
   int          rd_count, fails, cmp_count;
   int          cyc = 0;

   ecl_config_loader u_dut (.mclk(mclk), .reset(reset), .cfg_sense_input(sense),
      .mem_wait(mem_wait), .write_data0_line(wr0), .refresh_data1_line(rf1),
      .muxed_addr_data_lines(ad), .cycle_strobe_0_n(s0_n), .read_strobe_n(rd_n),
      .proc_clock_out_a(pclk), .cfg_out(cfg), .cfg_valid(valid), .ext_cfg_used(ext_used),
      .refresh_interval_clks(ref_clks));

   ecl_cfg_partner u_rom (.mclk(mclk), .reset(reset), .mode(mode), .line_sel(line_sel),
      .rom_bits(bits), .slow(slow), .write_data0_line(wr0), .refresh_data1_line(rf1),
      .muxed_addr_data_lines(ad), .cycle_strobe_0_n(s0_n), .read_strobe_n(rd_n),
      .cfg_sense_input(sense), .mem_wait(mem_wait), .rd_count(rd_count), .addr_err(err));

   always #10 mclk = ~mclk;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 100000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", name, e, g);
      end
   endtask

   task automatic chk_cfg(input ecl_cfg_t e);
      cmp_count++;
      if (cfg !== e)
      begin
         fails++;
         $display("wrong value cfg_out expected %0h seen %0h", e, cfg);
      end
   endtask

   // Scan bits are configuration values, least significant bit first in each field.
   function automatic ecl_cfg_t ext_model(input logic [35:0] b);
      ecl_cfg_t c;
      int       sum;
      sum = 0;
      for (int n = 0; n < 6; n++)
      begin
         c.t_len[n] = {1'b0, b[2*n +: 2]} + 3'h1;
         sum += c.t_len[n];
      end
      for (int j = 0; j < 4; j++)
         c.strobe[j] = b[12 + 5*j +: 5];
      c.refresh_code = b[33:32];
      c.refresh_en   = b[34];
      c.late_write   = b[35];
      c.proc_cycles  = 4'((sum + 1) / 2);
      return c;
   endfunction

   task automatic wait_low(input int which, input int lim);
      int n;
      n = 0;
      while ((which == 0 ? wr0 : which == 1 ? rf1 : ad[0]) !== 1'b0 && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic run(input logic [1:0] m, input int k, input logic [35:0] b, input logic sl);
      ecl_cfg_t e;
      int       t0;
      int       n;
      logic     ext;
      logic     p;
      mode     = m;
      line_sel = 6'(k);
      bits     = b;
      slow     = sl;
      reset    = 1'b1;
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      wait_low(0, 400);
      t0 = cyc;
      wait_low(1, 40);
      chk_val("refresh_line_fall", 32'h14, 32'(cyc - t0));
      t0 = cyc;
      wait_low(2, 40);
      chk_val("addr_line_fall", 32'h14, 32'(cyc - t0));
      n = 0;
      while (valid !== 1'b1 && n < 5000)
      begin
         @(negedge mclk);
         n++;
      end
      ext = (m == 2'h1 || m == 2'h3);
      e = ext ? ext_model(m == 2'h1 ? '1 : b) : (m == 2'h2 && k < 16) ? ECL_PRESETS[k] : dflt;
      chk_val("cfg_valid", 32'h1, {31'h0, valid});
      chk_cfg(e);
      chk_val("ext_cfg_used", {31'h0, ext}, {31'h0, ext_used});
      chk_val("refresh_clks", 32'(18 * (e.refresh_code + 1)), {25'h0, ref_clks});
      chk_val("read_count", 32'h24, 32'(rd_count));
      chk_val("addr_err", 32'h0, {31'h0, err});
      if (m == 2'h2 && (k == 8 || k == 9))
         chk_val("refresh_en", 32'h0, {31'h0, cfg.refresh_en});
      p = pclk;
      repeat (2) @(negedge mclk);
      chk_val("proc_clock_out_a", {31'h0, ~p}, {31'h0, pclk});
      repeat (98) @(negedge mclk);
      chk_cfg(e);
   endtask

   initial
   begin
      mclk = 1'b0;
      reset = 1'b1;
      mode = 2'h0;
      line_sel = 6'h00;
      bits = 36'h0;
      slow = 1'b0;
      dflt.t_len = {6{3'h4}};
      dflt.strobe = {5'h12, 5'h1e, 5'h1e, 5'h1f};
      dflt.late_write = 1'b1;
      dflt.refresh_en = 1'b1;
      dflt.refresh_code = 2'h3;
      dflt.proc_cycles = 4'hc;
      void'($urandom(32'ha1f8));
      run(2'h0, 0, 36'h0, 1'b0);
      run(2'h1, 0, 36'h0, 1'b1);
      for (int k = 0; k < 18; k++)
         run(2'h2, k < 16 ? k : 16 * (k - 15), 36'h0, 1'b0);
      repeat (3)
         run(2'h3, 0, 36'({$urandom, $urandom}), 1'($urandom));
      give_verdict();
   end
endmodule // ecl_config_loader_tb
